// *** core/asalu_core.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Pointer add sign-extends a 6-bit literal onto pointer 0 or 1; flags untouched.
// - Pointer sum wraps modulo 65536 instead of saturating.
// - AND literal with accumulator, result to accumulator, only zero flag changes.
// - Add literal to accumulator, result to accumulator, carry/digit carry/zero change.
// - AND accumulator with file register 0..127, only zero flag changes.
// - Add accumulator and file register 0..127, carry/digit carry/zero change.
// - File ops: dest 0 writes accumulator, dest 1 writes the file register.
// - Shift right moves bits 7..1 to 6..0, old bit 0 into carry.
// - Shift keeps bit 7 as sign copy; result goes where dest selects.
module asalu_core
  import asalu_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Avalon-MM slave.
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);

  // ****************************************************************
  // State.
  // ****************************************************************
  // Handshake state and the read data that it launches.
  asalu_bus_t  bus_reg;
  logic [31:0] readdata_reg;
  // Working registers of the datapath; reset clears every one of them.
  logic [7:0]  accum_reg;
  logic [15:0] ptr_reg [0:1];
  logic        carry_reg;
  logic        dcarry_reg;
  logic        zero_reg;
  // File registers are flops, so an operation reads its operand in the cycle it executes.
  logic [7:0]  fileMem_reg [0:FILE_DEPTH-1];

  // Zero test of an 8-bit result, shared by every flag-updating operation.
  function automatic logic isZero(input logic [7:0] v);
    isZero = (v == 8'h00);
  endfunction

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  // Accesses complete in the ACK state so every request sees exactly one wait cycle.
  wire       busReq   = read | write;
  wire       busDone  = busReq && (bus_reg == BUS_ACK);
  wire       busWr    = write && busDone;
  wire       inFile   = (address >= ADDR_FILE_LO);
  // Bits 1:0 are not decoded in the file window; any byte of a word selects it.
  wire [6:0] busIdx   = address[8:2];
  // Word registers need an exact match, so a stray address reaches nothing.
  wire       hitCmd   = (address == ADDR_CMD);
  wire       hitAcc   = (address == ADDR_ACCUM);
  wire       hitStat  = (address == ADDR_STATUS);
  wire       hitPtr0  = (address == ADDR_PTR0);
  wire       hitPtr1  = (address == ADDR_PTR1);

  // Unmapped addresses and the command word read back as zero.
  wire [31:0] rdMux =
      hitAcc  ? {24'h000000, accum_reg} :
      hitStat ? {29'h0, zero_reg, dcarry_reg, carry_reg} :
      hitPtr0 ? {16'h0000, ptr_reg[0]} :
      hitPtr1 ? {16'h0000, ptr_reg[1]} :
      inFile  ? {24'h000000, fileMem_reg[busIdx]} : 32'h0000_0000;

  // ****************************************************************
  // Datapath.
  // ****************************************************************
  asalu_cmd_t cmd;
  assign cmd = asalu_cmd_t'(writedata);
  // A command word write executes its operation at the edge that completes it.
  wire        exec     = busWr && hitCmd;
  wire [7:0]  fileVal  = fileMem_reg[cmd.fileAddr];
  wire        litOp    = (cmd.op == OP_AND_LIT_ACCUM) || (cmd.op == OP_ADD_LIT_ACCUM);
  // Operand B is the literal for literal ops and the addressed file register otherwise.
  wire [7:0]  opB      = litOp ? cmd.literal : fileVal;
  // Carry out of bit 7 and of bit 3 come from widened sums.
  wire [8:0]  sum9     = {1'b0, accum_reg} + {1'b0, opB};
  wire [4:0]  nib5     = {1'b0, accum_reg[3:0]} + {1'b0, opB[3:0]};
  wire [7:0]  andRes   = accum_reg & opB;
  // The shift copies bit 7 into itself, so a negative byte stays negative.
  wire [7:0]  asrRes   = {fileVal[7], fileVal[7:1]};
  // Sixteen-bit add drops the carry, so the pointer wraps at both ends.
  wire [15:0] ptrOld   = ptr_reg[cmd.ptrSel];
  wire [15:0] ptrSum   = ptrOld + {{10{cmd.literal[5]}}, cmd.literal[5:0]};

  // Operation decode; codes 0 and 7 match none of these, so they change nothing.
  // Literal operations ignore the destination bit and always write the accumulator.
  wire isAnd   = (cmd.op == OP_AND_LIT_ACCUM) || (cmd.op == OP_AND_ACCUM_FILE);
  wire isAdd   = (cmd.op == OP_ADD_LIT_ACCUM) || (cmd.op == OP_ADD_ACCUM_FILE);
  wire isAsr   = (cmd.op == OP_ASR_FILE);
  wire isFile  = (cmd.op == OP_AND_ACCUM_FILE) || (cmd.op == OP_ADD_ACCUM_FILE) || isAsr;
  wire [7:0] result = isAnd ? andRes : (isAdd ? sum9[7:0] : asrRes);
  wire aluOp   = isAnd || isAdd || isAsr;
  wire toFile  = exec && isFile && cmd.dest;
  wire toAccum = exec && aluOp && !(isFile && cmd.dest);
  wire ptrExec = exec && (cmd.op == OP_ADD_LIT_PTR);

  // ****************************************************************
  // Bus handshake and read data.
  // ****************************************************************
  // Waitrequest idles high; it drops for the single cycle that completes an access.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_reg      <= BUS_WAIT;
      readdata_reg <= RDATA_RST;
    end else begin
      case (bus_reg)
        BUS_WAIT: begin
          if (busReq) begin
            bus_reg      <= BUS_ACK;
            readdata_reg <= rdMux;
          end
        end
        BUS_ACK: bus_reg <= BUS_WAIT;
        default: bus_reg <= BUS_WAIT;
      endcase
    end
  end
  // Waitrequest is the WAIT bit of the one-hot state, so it comes straight from a flop.
  // Read data are captured on the first edge and stand unchanged at the completing edge.
  assign waitrequest = bus_reg[0];
  assign readdata    = readdata_reg;

  // ****************************************************************
  // Accumulator and flags.
  // ****************************************************************
  // Flag ownership: adds change all three, AND changes zero, the shift changes carry
  // and zero. Pointer adds and NOP leave every flag as it was.
  wire       swAcc     = busWr && hitAcc;
  wire       swStat    = busWr && hitStat;
  wire       updZero   = exec && aluOp;
  wire       updCarry  = exec && (isAdd || isAsr);
  wire       updDcarry = exec && isAdd;
  // The shift takes carry from the old bit 0; an add takes it from bit 8 of the sum.
  wire       carryRes  = isAsr ? fileVal[0] : sum9[8];

  // Next values. Software and the datapath share one bus access, so they never collide.
  wire [7:0] accum_next  = swAcc ? writedata[7:0] :
                           (toAccum ? result : accum_reg);
  wire       carry_next  = swStat ? writedata[STAT_CARRY_BIT] :
                           (updCarry ? carryRes : carry_reg);
  wire       dcarry_next = swStat ? writedata[STAT_DCARRY_BIT] :
                           (updDcarry ? nib5[4] : dcarry_reg);
  wire       zero_next   = swStat ? writedata[STAT_ZERO_BIT] :
                           (updZero ? isZero(result) : zero_reg);

  // Accumulator register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      accum_reg <= ACCUM_RST;
    end else begin
      accum_reg <= accum_next;
    end
  end

  // Status flags; a flag that the operation does not own keeps its value.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      carry_reg  <= FLAG_RST;
      dcarry_reg <= FLAG_RST;
      zero_reg   <= FLAG_RST;
    end else begin
      carry_reg  <= carry_next;
      dcarry_reg <= dcarry_next;
      zero_reg   <= zero_next;
    end
  end

  // ****************************************************************
  // Indirect pointers.
  // ****************************************************************
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_ptr
      wire swWr = busWr && ((gp == 0) ? hitPtr0 : hitPtr1);
      // Each pointer takes a software write or the pointer add, never both in one cycle.
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ptr_reg[gp] <= PTR_RST;
        end else if (swWr) begin
          ptr_reg[gp] <= writedata[15:0];
        end else if (ptrExec && (cmd.ptrSel == 1'(gp))) begin
          ptr_reg[gp] <= ptrSum;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // File registers.
  // ****************************************************************
  // Software and the datapath never write in the same cycle: one access at a time.
  genvar gf;
  generate
    for (gf = 0; gf < FILE_DEPTH; gf++) begin : g_file
      wire swWr = busWr && inFile && (busIdx == 7'(gf));
      // An operation writes back only when its destination bit selects the file.
      wire exWr = toFile && (cmd.fileAddr == 7'(gf));
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          fileMem_reg[gf] <= FILE_RST;
        end else if (swWr) begin
          fileMem_reg[gf] <= writedata[7:0];
        end else if (exWr) begin
          fileMem_reg[gf] <= result;
        end
      end
    end
  endgenerate

endmodule

// *** shared/asalu_pkg.sv ***
// ****************************************************************
// Register map, command layout and reset values.
// ****************************************************************
package asalu_pkg;

  // Byte addresses of the word registers on the Avalon-MM slave.
  localparam logic [9:0] ADDR_CMD      = 10'h000;
  localparam logic [9:0] ADDR_ACCUM    = 10'h004;
  localparam logic [9:0] ADDR_STATUS   = 10'h008;
  localparam logic [9:0] ADDR_PTR0     = 10'h00c;
  localparam logic [9:0] ADDR_PTR1     = 10'h010;
  // The file register window starts here, one word per file register.
  localparam logic [9:0] ADDR_FILE_LO  = 10'h200;

  // Status register field positions.
  localparam int STAT_CARRY_BIT  = 0;
  localparam int STAT_DCARRY_BIT = 1;
  localparam int STAT_ZERO_BIT   = 2;

  // Reset values.
  localparam logic [7:0]  ACCUM_RST   = 8'h00;
  localparam logic [7:0]  FILE_RST    = 8'h00;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic        FLAG_RST    = 1'b0;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // Operation codes carried in the command word.
  typedef enum logic [2:0] {
    OP_NOP               = 3'h0,
    OP_ADD_LIT_PTR       = 3'h1,
    OP_AND_LIT_ACCUM     = 3'h2,
    OP_ADD_LIT_ACCUM     = 3'h3,
    OP_AND_ACCUM_FILE    = 3'h4,
    OP_ADD_ACCUM_FILE    = 3'h5,
    OP_ASR_FILE          = 3'h6
  } asalu_op_t;

  // Command word as written to ADDR_CMD.
  typedef struct packed {
    logic [8:0] rsvd;
    logic [6:0] fileAddr;
    logic [7:0] literal;
    logic [2:0] pad;
    logic       ptrSel;
    logic       dest;
    asalu_op_t  op;
  } asalu_cmd_t;

  // Slave handshake states, one-hot.
  typedef enum logic [1:0] {
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } asalu_bus_t;

endpackage

// *** sim/asalu_properties.sv ***
`timescale 1ns/1ps
// Bus-level checks and a flag-keeping check; ALU results are compared by the bench.
module asalu_properties
  import asalu_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        nrst,
  // Avalon-MM slave as seen from outside.
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Read data only mean something at the edge that completes a read.
  wire logic rdDone = read && !waitrequest;
  property p_wait_one; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait cycle");
  property p_wait_back; !waitrequest |=> waitrequest; endproperty
  a_wait_back: assert property (p_wait_back) else $error("waitrequest low too long");
  property p_acc_w; rdDone && address == ADDR_ACCUM |-> readdata[31:8] == 24'h0; endproperty
  a_acc_w: assert property (p_acc_w) else $error("accumulator wider than a byte");
  property p_flag_w; rdDone && address == ADDR_STATUS |-> readdata[31:3] == 29'h0; endproperty
  a_flag_w: assert property (p_flag_w) else $error("status has extra bits");
  property p_ptr_w;
    rdDone && (address == ADDR_PTR0 || address == ADDR_PTR1) |-> readdata[31:16] == 16'h0;
  endproperty
  a_ptr_w: assert property (p_ptr_w) else $error("pointer beyond 16 bits");
  property p_file_w; rdDone && address >= ADDR_FILE_LO |-> readdata[31:8] == 24'h0; endproperty
  a_file_w: assert property (p_file_w) else $error("file register wider than a byte");
  property p_cmd_zero; rdDone && address == ADDR_CMD |-> readdata == 32'h0; endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command word reads nonzero");
  property p_rd_hold; !read && !write |=> $stable(readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved while idle");
  // Flags that each operation may change: adds all three, AND zero, shift carry and zero.
  wire logic       wrDone   = write && !waitrequest;
  wire logic [2:0] cmdOp    = writedata[2:0];
  wire logic [2:0] flagMask =
      (cmdOp == OP_ADD_LIT_ACCUM || cmdOp == OP_ADD_ACCUM_FILE) ? 3'h7 :
      (cmdOp == OP_AND_LIT_ACCUM || cmdOp == OP_AND_ACCUM_FILE) ? 3'h4 :
      (cmdOp == OP_ASR_FILE) ? 3'h5 : 3'h0;
  // Last flag values seen on the bus, and which of them no operation has touched since.
  logic [2:0] statSeen_reg;
  logic [2:0] statKnown_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      statSeen_reg  <= {3{FLAG_RST}};
      statKnown_reg <= 3'h7;
    end else if (wrDone && address == ADDR_STATUS) begin
      statSeen_reg  <= writedata[2:0];
      statKnown_reg <= 3'h7;
    end else if (wrDone && address == ADDR_CMD) begin
      statKnown_reg <= statKnown_reg & ~flagMask;
    end else if (rdDone && address == ADDR_STATUS) begin
      statSeen_reg  <= readdata[2:0];
      statKnown_reg <= 3'h7;
    end
  end
  property p_flags_kept;
    rdDone && address == ADDR_STATUS |->
      ((readdata[2:0] ^ statSeen_reg) & statKnown_reg) == 3'h0;
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flag moved");
endmodule

bind asalu_core asalu_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest));

// *** sim/add_and_shift_alu_ops_bench.sv ***
`timescale 1ns/1ps
module add_and_shift_alu_ops_bench
  import asalu_pkg::*;
;
  logic        clk_sys, nrst, read, write, waitrequest;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, rdVal;
  int          error_cnt, samples_checked;

  asalu_core DUT (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One Avalon access; the wait is bounded so a stuck slave cannot hang the run.
  task automatic access(logic isWr, logic [9:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    read <= !isWr;
    write <= isWr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        error_cnt++;
        end_sim();
      end
    end while (waitrequest !== 1'b0);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(logic [9:0] a, logic [31:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd(string what, logic [9:0] a, logic [31:0] exp);
    access(1'b0, a, 32'h0);
    check(what, rdVal, exp);
  endtask

  task automatic run(asalu_op_t op, logic dst, logic sel, logic [7:0] lit, logic [6:0] fa);
    wr(ADDR_CMD, {9'h0, fa, lit, 3'h0, sel, dst, op});
  endtask

  // Main sequence: each operation starts from known register contents.
  initial begin
    {nrst, read, write, address, writedata, error_cnt, samples_checked} = '0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd("accum rst", ADDR_ACCUM, 32'h0);
    rd("ptr1 rst", ADDR_PTR1, 32'h0);
    wr(ADDR_STATUS, 32'h5);
    wr(ADDR_PTR0, 32'hffff);
    run(OP_ADD_LIT_PTR, 1'b0, 1'b0, 8'h1f, 7'h0);
    rd("ptr0 up", ADDR_PTR0, 32'h1e);
    run(OP_ADD_LIT_PTR, 1'b0, 1'b1, 8'he0, 7'h0);
    rd("ptr1 down", ADDR_PTR1, 32'hffe0);
    rd("ptr0 kept", ADDR_PTR0, 32'h1e);
    rd("ptr flags", ADDR_STATUS, 32'h5);
    wr(ADDR_ACCUM, 32'hf0);
    wr(ADDR_STATUS, 32'h3);
    run(OP_AND_LIT_ACCUM, 1'b0, 1'b0, 8'h0f, 7'h0);
    rd("andl acc", ADDR_ACCUM, 32'h0);
    rd("andl flags", ADDR_STATUS, 32'h7);
    wr(ADDR_ACCUM, 32'h88);
    run(OP_ADD_LIT_ACCUM, 1'b0, 1'b0, 8'h88, 7'h0);
    rd("addl acc", ADDR_ACCUM, 32'h10);
    rd("addl flags", ADDR_STATUS, 32'h3);
    run(OP_ADD_LIT_ACCUM, 1'b1, 1'b0, 8'hf0, 7'h0);
    rd("addl zero", ADDR_STATUS, 32'h5);
    rd("addl dest", ADDR_ACCUM, 32'h0);
    rd("addl file", ADDR_FILE_LO, 32'h0);
    wr(10'h3fc, 32'h3c);
    wr(ADDR_ACCUM, 32'hf5);
    wr(ADDR_STATUS, 32'h3);
    run(OP_AND_ACCUM_FILE, 1'b1, 1'b0, 8'h0, 7'h7f);
    rd("andf file", 10'h3fc, 32'h34);
    rd("andf acc", ADDR_ACCUM, 32'hf5);
    rd("andf flags", ADDR_STATUS, 32'h3);
    run(OP_AND_ACCUM_FILE, 1'b0, 1'b0, 8'h0, 7'h7f);
    rd("andf to acc", ADDR_ACCUM, 32'h34);
    wr(ADDR_FILE_LO, 32'h0f);
    wr(ADDR_ACCUM, 32'h01);
    run(OP_ADD_ACCUM_FILE, 1'b1, 1'b0, 8'h0, 7'h0);
    rd("addf file", ADDR_FILE_LO, 32'h10);
    rd("addf flags", ADDR_STATUS, 32'h2);
    wr(10'h214, 32'h81);
    run(OP_ASR_FILE, 1'b0, 1'b0, 8'h0, 7'h5);
    rd("asr acc", ADDR_ACCUM, 32'hc0);
    rd("asr src", 10'h214, 32'h81);
    rd("asr flags", ADDR_STATUS, 32'h3);
    wr(10'h214, 32'h01);
    run(OP_ASR_FILE, 1'b1, 1'b0, 8'h0, 7'h5);
    rd("asr file", 10'h214, 32'h0);
    rd("asr zero", ADDR_STATUS, 32'h7);
    run(OP_NOP, 1'b1, 1'b0, 8'hff, 7'h5);
    rd("nop file", 10'h214, 32'h0);
    rd("nop acc", ADDR_ACCUM, 32'hc0);
    rd("nop flags", ADDR_STATUS, 32'h7);
    rd("cmd read", ADDR_CMD, 32'h0);
    rd("unmapped", 10'h100, 32'h0);
    end_sim();
  end
endmodule
